//--- rtl/bwib_seq.sv
// Sequencer for bursting and burst-inhibited multi-transfer bus operations
// Function
// R1 - Line write walks four longwords in block
// R2 - Longword steps low address bits on narrow ports
// R3 - Word steps address bit zero on byte port
// R4 - Bursting: size code shows operand size
// R5 - Inhibited: size code shows port width
// R6 - Inhibited mode never shows line size
// R7 - Bursting write takes two to sixteen beats
// R8 - First clock: address, controls, write, start
// R9 - Second clock: start off, privilege, data
// R10 - Wait states hold data until acknowledge
// R11 - Target latches data on acknowledge clock
// R12 - Burst beat advances address without start
// R13 - Release data bus after final beat
// R14 - Burst disabled, not DRAM, and wide: inhibited sequence
// R15 - DRAM wide accesses are always bursted
// R16 - Inhibited read repeats ordinary reads fully
// R17 - Inhibited: new start each following transfer
// R18 - Burst when enabled or DRAM, wide
// R19 - Longword placed on all lanes, wide port
`timescale 1ns/1ps
module bwib_seq #(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Operation request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [27:0] REQ_ADDR,
    input wire logic REQ_WRITE,
    input wire logic [1:0] REQ_OPSIZE,
    input wire logic [1:0] REQ_PORT,
    input wire logic [1:0] REQ_TYPE,
    input wire logic REQ_KIND,
    input wire logic REQ_PRIV,
    input wire logic REQ_BURST_EN,
    input wire logic REQ_DRAM,
    // Write data stream
    input wire logic WD_VALID,
    output logic WD_READY,
    input wire logic [31:0] WD_DATA,
    // Read data and completion
    output logic RD_VALID,
    output logic [31:0] RD_DATA,
    output logic RD_LAST,
    output logic DONE,
    // External bus
    output logic [27:0] ADDR,
    output logic [1:0] ACCESS_TYPE_CODE,
    output logic ACCESS_MODE_FLAG,
    output logic [1:0] XFER_SIZE_CODE,
    output logic RW,
    output logic TRANSFER_START_N,
    input wire logic XFER_ACK_N,
    input wire logic [31:0] DATA_IN,
    output logic [31:0] DATA_OUT,
    output logic DATA_OE_N
);
    bwib_pkg::bwib_state_type state_ff; // Sequencer state
    bwib_pkg::bwib_state_type nxt_state; // Its next value
    logic [27:0] addr_ff; // Current transfer address
    logic write_ff; // Operation is a write
    logic [1:0] type_ff; // Access type
    logic kind_ff; // Code or data, first clock
    logic priv_ff; // Privilege, later clocks
    logic [1:0] size_ff; // Size code on the lines
    logic [1:0] op_ff; // Operand size
    logic burst_ff; // Bursted operation
    logic inhib_ff; // Burst-inhibited operation
    logic dram_ff; // Target is DRAM
    logic [3:0] mask_ff; // Operand block mask on low address
    logic [4:0] step_ff; // Address step per beat
    logic [4:0] left_ff; // Beats left after current
    logic [1:0] slice_ff; // Port slice within a data item
    logic [1:0] slices_m1_ff; // Slices per item minus one
    logic [2:0] port_lg_ff; // Port width, log2 of bytes
    logic [2:0] item_lg_ff; // Data item width, log2 of bytes
    logic [2:0] lane_lg_ff; // Replicated lane width, log2 of bytes
    logic rd_valid_ff;
    logic [31:0] rd_data_ff;
    logic rd_last_ff;
    logic done_ff;

    // Request decode
    logic [2:0] req_op_lg;
    logic [2:0] req_port_lg;
    logic [2:0] req_item_lg;
    logic req_wide;
    logic req_burst;
    logic [4:0] req_opb;

    // Beat handshake and buffer head
    logic ack;
    logic beat_done;
    logic last_beat;
    logic slice_last;
    logic wd_pop;
    logic wd_head_valid;
    logic wd_more;
    logic [31:0] wd_head;
    logic [3:0] nxt_low;
    logic [31:0] just;
    logic [31:0] sel;
    logic [6:0] shamt;
    logic [2:0] lgb;

    // Write data buffer; its ready stalls the producer
    bwib_pair_buf #(
        .WIDTH(bwib_pkg::DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_wbuf (
        .CLK(CLK),
        .NRST(NRST),
        .in_valid(WD_VALID),
        .in_ready(WD_READY),
        .in_data(WD_DATA),
        .out_valid(wd_head_valid),
        .out_ready(wd_pop),
        .out_data(wd_head),
        .out_more(wd_more)
    );

    // Operand against port width decides burst or inhibited
    always_comb begin
        req_op_lg = bwib_pkg::size_lg(REQ_OPSIZE);
        req_port_lg = (REQ_PORT == bwib_pkg::SZ_LINE) ? bwib_pkg::LG_LONG
                                                      : bwib_pkg::size_lg(REQ_PORT);
        req_item_lg = (req_op_lg > bwib_pkg::LG_LONG) ? bwib_pkg::LG_LONG : req_op_lg;
        req_wide = req_op_lg > req_port_lg;
        req_burst = req_wide && (REQ_BURST_EN || REQ_DRAM); // R18 R15
        req_opb = 5'h01 << req_op_lg;
    end

    // Accept a request when idle; a write needs its first item buffered
    assign REQ_READY = (state_ff == bwib_pkg::ST_IDLE) && (!REQ_WRITE || wd_head_valid);

    // Beat bookkeeping
    assign ack = !XFER_ACK_N;
    assign beat_done = (state_ff == bwib_pkg::ST_DATA) && ack; // R10
    assign last_beat = (left_ff == 5'h00);
    assign slice_last = (slice_ff == slices_m1_ff);
    assign wd_pop = beat_done && write_ff && slice_last;

    // State sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            bwib_pkg::ST_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    nxt_state = bwib_pkg::ST_START;
                end
            end
            bwib_pkg::ST_START: begin
                nxt_state = bwib_pkg::ST_DATA; // R9
            end
            bwib_pkg::ST_DATA: begin
                if (!ack) begin
                    nxt_state = bwib_pkg::ST_DATA; // R10
                end else if (last_beat) begin
                    nxt_state = bwib_pkg::ST_IDLE; // R13
                end else if (burst_ff) begin
                    nxt_state = bwib_pkg::ST_DATA; // R12
                end else if (!write_ff || !wd_pop || wd_more) begin
                    nxt_state = bwib_pkg::ST_START; // R17 R16
                end else begin
                    nxt_state = bwib_pkg::ST_GAP;
                end
            end
            bwib_pkg::ST_GAP: begin
                // Wait for the next write item before a new start
                if (!write_ff || wd_head_valid) begin
                    nxt_state = bwib_pkg::ST_START; // R17
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state_ff <= bwib_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Operation attributes captured with the request
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            write_ff <= 1'b0;
            type_ff <= bwib_pkg::RST_CODE;
            kind_ff <= 1'b0;
            priv_ff <= 1'b0;
            size_ff <= bwib_pkg::RST_CODE;
            op_ff <= bwib_pkg::RST_CODE;
            burst_ff <= 1'b0;
            inhib_ff <= 1'b0;
            dram_ff <= 1'b0;
            mask_ff <= 4'h0;
            step_ff <= 5'h00;
            port_lg_ff <= 3'h0;
            item_lg_ff <= 3'h0;
            lane_lg_ff <= 3'h0;
            slices_m1_ff <= 2'h0;
        end else if (REQ_VALID && REQ_READY) begin
            write_ff <= REQ_WRITE;
            type_ff <= REQ_TYPE;
            kind_ff <= REQ_KIND;
            priv_ff <= REQ_PRIV;
            // Wide and not bursted: port width; else operand size
            size_ff <= (req_wide && !req_burst) ? REQ_PORT : REQ_OPSIZE; // R4 R5 R6 R14
            op_ff <= REQ_OPSIZE;
            burst_ff <= req_burst;
            inhib_ff <= req_wide && !req_burst; // R14
            dram_ff <= REQ_DRAM;
            mask_ff <= 4'(req_opb - 5'h01);
            step_ff <= req_wide ? (5'h01 << req_port_lg) : 5'h00; // R2 R3
            port_lg_ff <= req_port_lg;
            item_lg_ff <= req_item_lg;
            lane_lg_ff <= (req_item_lg < req_port_lg) ? req_item_lg : req_port_lg;
            slices_m1_ff <= (req_item_lg > req_port_lg)
                          ? 2'((3'h1 << (req_item_lg - req_port_lg)) - 3'h1) : 2'h0;
        end
    end

    // Next low address stays inside the aligned operand block
    assign nxt_low = (addr_ff[3:0] & ~mask_ff) | ((addr_ff[3:0] + step_ff[3:0]) & mask_ff);

    // Address register steps after each acknowledged beat but the last
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            addr_ff <= bwib_pkg::RST_ADDR;
        end else if (REQ_VALID && REQ_READY) begin
            addr_ff <= REQ_ADDR; // R8
        end else if (beat_done && !last_beat) begin
            addr_ff <= {addr_ff[27:4], nxt_low}; // R1 R2 R3 R12 R17
        end
    end

    // Beats left after the current one: one to fifteen for a wide operand
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            left_ff <= 5'h00;
        end else if (REQ_VALID && REQ_READY) begin
            left_ff <= req_wide ? 5'((5'h01 << (req_op_lg - req_port_lg)) - 5'h01)
                                : 5'h00; // R7 R16
        end else if (beat_done && !last_beat) begin
            left_ff <= left_ff - 5'h01;
        end
    end

    // Slice index within the current write item
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            slice_ff <= 2'h0;
        end else if (REQ_VALID && REQ_READY) begin
            slice_ff <= 2'h0;
        end else if (beat_done) begin
            slice_ff <= slice_last ? 2'h0 : slice_ff + 2'h1;
        end
    end

    // Left-justify the item, pick the slice, replicate over the lanes
    always_comb begin
        unique case (item_lg_ff)
            3'h0: just = {wd_head[7:0], 24'h000000};
            3'h1: just = {wd_head[15:0], 16'h0000};
            default: just = wd_head;
        endcase
        lgb = port_lg_ff + 3'h3;
        shamt = {5'h00, slice_ff} << lgb;
        sel = just << shamt;
        unique case (lane_lg_ff)
            3'h0: DATA_OUT = {4{sel[31:24]}};
            3'h1: DATA_OUT = {2{sel[31:16]}};
            default: DATA_OUT = sel; // R19
        endcase
    end

    // Bus controls decoded from the state flop
    assign TRANSFER_START_N = (state_ff != bwib_pkg::ST_START); // R8 R17
    assign DATA_OE_N = !(write_ff && (state_ff == bwib_pkg::ST_DATA)); // R9 R10 R13
    assign ACCESS_MODE_FLAG = (state_ff == bwib_pkg::ST_START) ? kind_ff : priv_ff; // R8 R9
    assign RW = !(write_ff && (state_ff != bwib_pkg::ST_IDLE)); // R8
    assign ADDR = addr_ff;
    assign ACCESS_TYPE_CODE = type_ff;
    assign XFER_SIZE_CODE = size_ff;

    // Read beats and completion reported from flops
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= bwib_pkg::RST_DATA;
            rd_last_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            rd_valid_ff <= beat_done && !write_ff; // R16
            rd_last_ff <= beat_done && !write_ff && last_beat;
            done_ff <= beat_done && last_beat;
            if (beat_done && !write_ff) begin
                rd_data_ff <= DATA_IN;
            end
        end
    end

    assign RD_VALID = rd_valid_ff;
    assign RD_DATA = rd_data_ff;
    assign RD_LAST = rd_last_ff;
    assign DONE = done_ff;

    // Checks on the sequencing
    sequence s_last_ack;
        beat_done && last_beat;
    endsequence

    sequence s_mid_ack;
        beat_done && !last_beat;
    endsequence

    a_start_one_cycle: assert property (@(posedge CLK) disable iff (!NRST) // R8
        !TRANSFER_START_N |=> TRANSFER_START_N)
        else $error("transfer start held over one cycle");

    a_write_first_clk: assert property (@(posedge CLK) disable iff (!NRST) // R8
        (!TRANSFER_START_N && write_ff) |-> (!RW && DATA_OE_N && ACCESS_MODE_FLAG == kind_ff))
        else $error("first clock of write shows wrong controls");

    a_write_data_on: assert property (@(posedge CLK) disable iff (!NRST) // R9
        (!TRANSFER_START_N && write_ff) |=> (!DATA_OE_N && ACCESS_MODE_FLAG == priv_ff))
        else $error("write data not driven in second clock");

    a_wait_hold: assert property (@(posedge CLK) disable iff (!NRST) // R10
        (!DATA_OE_N && XFER_ACK_N) |=> (!DATA_OE_N && $stable(DATA_OUT) && $stable(ADDR)))
        else $error("data or address moved during wait state");

    // A new request may be taken in the done cycle, so only that cycle is checked
    a_bus_release: assert property (@(posedge CLK) disable iff (!NRST) // R13
        s_last_ack |=> (DATA_OE_N && TRANSFER_START_N && RW && DONE))
        else $error("data bus not released after final beat");

    a_burst_advance: assert property (@(posedge CLK) disable iff (!NRST) // R12
        (s_mid_ack and burst_ff) |=> (TRANSFER_START_N && ADDR != $past(ADDR)))
        else $error("burst beat restarted or kept its address");

    a_inhib_restart: assert property (@(posedge CLK) disable iff (!NRST) // R17
        (s_mid_ack and inhib_ff) |=> (!TRANSFER_START_N || state_ff == bwib_pkg::ST_GAP))
        else $error("inhibited transfer did not restart");

    a_no_line_inhib: assert property (@(posedge CLK) disable iff (!NRST) // R6
        (inhib_ff && state_ff != bwib_pkg::ST_IDLE) |-> XFER_SIZE_CODE != bwib_pkg::SZ_LINE)
        else $error("line size shown in inhibited mode");

    a_burst_size: assert property (@(posedge CLK) disable iff (!NRST) // R4
        (burst_ff && state_ff != bwib_pkg::ST_IDLE) |-> XFER_SIZE_CODE == op_ff)
        else $error("bursting size code is not the operand size");

    a_dram_bursts: assert property (@(posedge CLK) disable iff (!NRST) // R15
        (dram_ff && state_ff != bwib_pkg::ST_IDLE) |-> !inhib_ff)
        else $error("DRAM access sequenced burst-inhibited");

endmodule : bwib_seq

//--- rtl/bwib_pkg.sv
// Shared constants, types and decoding for the multi-transfer bus sequencer
package bwib_pkg;

    // Size codes on the size lines, also used for operand and port width
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_LINE = 2'h3;

    // Port width codes share the size encoding
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_16 = 2'h2;
    localparam logic [1:0] PORT_8 = 2'h1;

    // Bus widths
    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;

    // Largest transfer lane, as log2 of bytes
    localparam logic [2:0] LG_LONG = 3'h2;

    // Reset values of the bus outputs
    localparam logic [27:0] RST_ADDR = 28'h0000000;
    localparam logic [1:0] RST_CODE = 2'h0;
    localparam logic [31:0] RST_DATA = 32'h00000000;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_GAP = 2'b11
    } bwib_state_type;

    // Log2 of the byte count of a size code
    function automatic logic [2:0] size_lg(input logic [1:0] code);
        logic [2:0] lg;
        lg = 3'h2;
        unique case (code)
            SZ_BYTE: lg = 3'h0;
            SZ_WORD: lg = 3'h1;
            SZ_LONG: lg = 3'h2;
            SZ_LINE: lg = 3'h4;
        endcase
        return lg;
    endfunction : size_lg

endpackage : bwib_pkg

//--- rtl/bwib_pair_buf.sv
// Small valid/ready buffer in the write data path
`timescale 1ns/1ps
module bwib_pair_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // At least two entries held
    output logic out_more
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH]; // Entry storage
    logic [PW-1:0] wr_ptr_ff; // Next entry to fill
    logic [PW-1:0] rd_ptr_ff; // Oldest entry
    logic [PW:0] count_ff; // Entries held
    logic push;
    logic pop;

    // Handshakes and flags
    assign in_ready = (count_ff != (PW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_more = (count_ff > (PW+1)'(1));
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + PW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + PW'(1);
            end
        end
    end

    // Occupancy
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + (PW+1)'(1);
        end else if (pop && !push) begin
            count_ff <= count_ff - (PW+1)'(1);
        end
    end

endmodule : bwib_pair_buf

//--- verification/bwib_target.sv
// Bus target model: acknowledges beats with wait states and logs each one
`timescale 1ns/1ps
module bwib_target (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Bus from the sequencer
    input wire logic [27:0] ADDR,
    input wire logic [1:0] ACCESS_TYPE_CODE,
    input wire logic [1:0] XFER_SIZE_CODE,
    input wire logic RW,
    input wire logic TRANSFER_START_N,
    input wire logic ACCESS_MODE_FLAG,
    input wire logic [31:0] DATA_OUT,
    input wire logic DATA_OE_N,
    output logic XFER_ACK_N,
    output logic [31:0] DATA_IN,
    // Settings for the coming operation
    input wire logic [4:0] beats,
    input wire logic burst,
    input wire logic [1:0] waits
);
    logic [4:0] rem; // Beats left under the current start
    logic [1:0] wc; // Wait cycles left in this beat
    logic alt = 1'b0; // Filler level, flips every cycle
    logic [27:0] lg_addr [0:127]; // Address seen at each acknowledged beat
    logic [31:0] lg_data [0:127]; // Data latched at each acknowledged beat
    logic [6:0] lg_ctl [0:127]; // Type, size, direction, mode, enable per beat
    logic ts_mode; // Mode flag seen in the latest start clock
    int n_beat = 0; // Beats acknowledged so far
    int n_ts = 0; // Start clocks seen so far

    // Read data only while answering; otherwise a changing pattern
    assign DATA_IN = XFER_ACK_N ? {32{alt}} : {4'hD, ADDR};

    // Acknowledge, wait and logging
    always @(posedge CLK) begin
        alt <= ~alt;
        XFER_ACK_N <= 1'b1;
        if (!NRST) begin
            rem <= 5'h0;
        end else if (!TRANSFER_START_N) begin
            // New start: one beat unless the bus bursts
            rem <= burst ? beats : 5'h1;
            wc <= waits;
            n_ts <= n_ts + 1;
            ts_mode <= ACCESS_MODE_FLAG;
            if (waits == 2'h0) XFER_ACK_N <= 1'b0;
        end else if (rem != 5'h0 && !XFER_ACK_N) begin
            // Latch what stands on the bus at the acknowledge edge
            lg_addr[n_beat] <= ADDR;
            lg_data[n_beat] <= DATA_OUT;
            lg_ctl[n_beat] <= {ACCESS_TYPE_CODE, XFER_SIZE_CODE, RW, ACCESS_MODE_FLAG, DATA_OE_N};
            n_beat <= n_beat + 1;
            rem <= rem - 5'h1;
            wc <= waits;
            if (rem > 5'h1 && waits == 2'h0) XFER_ACK_N <= 1'b0;
        end else if (rem != 5'h0) begin
            // Wait state: answer once the count runs out
            wc <= wc - 2'h1;
            if (wc == 2'h1) XFER_ACK_N <= 1'b0;
        end
    end
endmodule : bwib_target

//--- verification/burst_write_inhibited_read_bus_tb.sv
// Self-checking bench for the multi-transfer bus sequencer
`timescale 1ns/1ps
module burst_write_inhibited_read_bus_tb;
    // Clock, reset and request side
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic REQ_VALID = 1'b0;
    logic [27:0] REQ_ADDR = 28'h0;
    logic REQ_WRITE = 1'b0;
    logic [1:0] REQ_OPSIZE = 2'h0;
    logic [1:0] REQ_PORT = 2'h0;
    logic [1:0] REQ_TYPE = 2'h0;
    logic REQ_KIND = 1'b1;
    logic REQ_PRIV = 1'b0;
    logic REQ_BURST_EN = 1'b0;
    logic REQ_DRAM = 1'b0;
    logic WD_VALID = 1'b0;
    logic [31:0] WD_DATA = 32'h0;
    // Design outputs and bus
    logic REQ_READY, WD_READY, RD_VALID, RD_LAST, DONE, ACCESS_MODE_FLAG, RW;
    logic TRANSFER_START_N, XFER_ACK_N, DATA_OE_N;
    logic [31:0] RD_DATA, DATA_IN, DATA_OUT;
    logic [27:0] ADDR;
    logic [1:0] ACCESS_TYPE_CODE, XFER_SIZE_CODE;
    // Target settings
    logic [4:0] beats = 5'h1;
    logic tburst = 1'b0;
    logic [1:0] waits = 2'h0;
    logic [31:0] wq [$]; // Write items waiting for the buffer
    int n_errors = 0;
    int check_count = 0;

    always #2.5 CLK = ~CLK;

    bwib_seq u_dut (.CLK(CLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE), .REQ_OPSIZE(REQ_OPSIZE),
        .REQ_PORT(REQ_PORT), .REQ_TYPE(REQ_TYPE), .REQ_KIND(REQ_KIND), .REQ_PRIV(REQ_PRIV),
        .REQ_BURST_EN(REQ_BURST_EN), .REQ_DRAM(REQ_DRAM), .WD_VALID(WD_VALID),
        .WD_READY(WD_READY), .WD_DATA(WD_DATA), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
        .RD_LAST(RD_LAST), .DONE(DONE), .ADDR(ADDR), .ACCESS_TYPE_CODE(ACCESS_TYPE_CODE),
        .ACCESS_MODE_FLAG(ACCESS_MODE_FLAG), .XFER_SIZE_CODE(XFER_SIZE_CODE), .RW(RW),
        .TRANSFER_START_N(TRANSFER_START_N), .XFER_ACK_N(XFER_ACK_N), .DATA_IN(DATA_IN),
        .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N));

    bwib_target u_tgt (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .ACCESS_TYPE_CODE(ACCESS_TYPE_CODE),
        .XFER_SIZE_CODE(XFER_SIZE_CODE), .RW(RW), .TRANSFER_START_N(TRANSFER_START_N),
        .ACCESS_MODE_FLAG(ACCESS_MODE_FLAG), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
        .XFER_ACK_N(XFER_ACK_N), .DATA_IN(DATA_IN), .beats(beats), .burst(tburst),
        .waits(waits));

    // Feeds queued write items into the buffer
    always @(posedge CLK) begin
        if (WD_VALID && WD_READY) wq.delete(0);
        WD_VALID <= (wq.size() > 0);
        if (wq.size() > 0) WD_DATA <= wq[0];
    end

    // Compares one value and counts it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // Byte count of a size code
    function automatic int nbytes(input logic [1:0] c);
        return (c == bwib_pkg::SZ_BYTE) ? 1 : (c == bwib_pkg::SZ_WORD) ? 2 :
            (c == bwib_pkg::SZ_LINE) ? 16 : 4;
    endfunction : nbytes

    // Write item k, cut to the item width
    function automatic logic [31:0] item(input int k, input int ib);
        logic [31:0] v;
        v = 32'hA1B2C3D4 + 32'(k) * 32'h1F2E3D4C;
        return (ib == 1) ? (v & 32'hFF) : (ib == 2) ? (v & 32'hFFFF) : v;
    endfunction : item

    // Runs one operation and judges every beat the target latched
    task automatic run_op(input logic [27:0] a, input logic wr, input logic [1:0] osz,
        input logic [1:0] psz, input logic ben, input logic dram, input logic [1:0] w);
        int ob, pb, nb, ib, sl, b0, t0, nrd, tmo, i;
        logic bst;
        logic [27:0] ea;
        logic [31:0] ch, ed;
        ob = nbytes(osz);
        pb = nbytes(psz);
        nb = ob / pb;
        ib = (ob > 4) ? 4 : ob;
        sl = ib / pb;
        bst = ben | dram;
        b0 = u_tgt.n_beat;
        t0 = u_tgt.n_ts;
        nrd = 0;
        tmo = 0;
        if (wr) for (i = 0; i < nb / sl; i++) wq.push_back(item(i, ib));
        @(posedge CLK);
        beats <= 5'(nb);
        tburst <= bst;
        waits <= w;
        REQ_ADDR <= a;
        REQ_WRITE <= wr;
        REQ_OPSIZE <= osz;
        REQ_PORT <= psz;
        REQ_TYPE <= osz;
        REQ_BURST_EN <= ben;
        REQ_DRAM <= dram;
        // Mode flags differ in start and later clocks, and vary per operation
        REQ_PRIV <= a[8];
        REQ_KIND <= ~a[8];
        REQ_VALID <= 1'b1;
        do begin
            @(negedge CLK);
            tmo++;
        end while (REQ_READY !== 1'b1 && tmo < 50);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        while (tmo < 300) begin
            @(negedge CLK);
            tmo++;
            if (RD_VALID === 1'b1) begin
                ea = (a & ~28'(ob - 1)) | ((a + 28'(nrd * pb)) & 28'(ob - 1));
                check(RD_DATA, {4'hD, ea});
                check(32'(RD_LAST), 32'(nrd == nb - 1));
                nrd++;
            end
            if (DONE === 1'b1) break;
        end
        if (tmo >= 300) begin
            n_errors++;
            $display("[FAIL] t=%0t operation did not finish", $time);
            end_of_test();
        end
        check(32'(DATA_OE_N), 32'h1);
        check(32'(nrd), wr ? 32'h0 : 32'(nb));
        check(32'(u_tgt.n_beat - b0), 32'(nb));
        check(32'(u_tgt.n_ts - t0), bst ? 32'h1 : 32'(nb));
        check(32'(u_tgt.ts_mode), 32'(REQ_KIND));
        for (i = 0; i < nb; i++) begin
            ea = (a & ~28'(ob - 1)) | ((a + 28'(i * pb)) & 28'(ob - 1));
            check(32'(u_tgt.lg_addr[b0 + i]), 32'(ea));
            check(32'(u_tgt.lg_ctl[b0 + i][4:3]), 32'(bst ? osz : psz));
            check(32'(u_tgt.lg_ctl[b0 + i][6:5]), 32'(osz));
            check(32'(u_tgt.lg_ctl[b0 + i][2:0]), 32'({~wr, REQ_PRIV, ~wr}));
            if (!bst) check(32'(u_tgt.lg_ctl[b0 + i][4:3] == 2'h3), 32'h0);
            if (wr) begin
                ch = item(i / sl, ib) >> (8 * (ib - pb * (i % sl + 1)));
                ed = (pb == 1) ? {4{ch[7:0]}} : (pb == 2) ? {2{ch[15:0]}} : ch;
                check(u_tgt.lg_data[b0 + i], ed);
            end
        end
    endtask : run_op

    // Main sequence
    initial begin
        repeat (6) @(posedge CLK);
        NRST <= 1'b1;
        run_op(28'h0000108, 1'b1, bwib_pkg::SZ_LINE, bwib_pkg::PORT_32, 1'b1, 1'b0, 2'h1);
        run_op(28'h0000202, 1'b1, bwib_pkg::SZ_WORD, bwib_pkg::PORT_8, 1'b1, 1'b0, 2'h0);
        run_op(28'h0000304, 1'b1, bwib_pkg::SZ_LONG, bwib_pkg::PORT_16, 1'b0, 1'b0, 2'h2);
        run_op(28'h0000314, 1'b1, bwib_pkg::SZ_LONG, bwib_pkg::PORT_16, 1'b0, 1'b1, 2'h0);
        run_op(28'h0000310, 1'b0, bwib_pkg::SZ_LONG, bwib_pkg::PORT_8, 1'b0, 1'b0, 2'h0);
        run_op(28'h0000404, 1'b0, bwib_pkg::SZ_LONG, bwib_pkg::PORT_16, 1'b0, 1'b1, 2'h1);
        run_op(28'h0000508, 1'b0, bwib_pkg::SZ_LINE, bwib_pkg::PORT_32, 1'b0, 1'b0, 2'h0);
        run_op(28'h000060C, 1'b0, bwib_pkg::SZ_LINE, bwib_pkg::PORT_16, 1'b0, 1'b0, 2'h1);
        run_op(28'h0000704, 1'b0, bwib_pkg::SZ_LINE, bwib_pkg::PORT_8, 1'b1, 1'b0, 2'h0);
        run_op(28'h0000810, 1'b0, bwib_pkg::SZ_LINE, bwib_pkg::PORT_8, 1'b0, 1'b0, 2'h0);
        run_op(28'h0000902, 1'b0, bwib_pkg::SZ_WORD, bwib_pkg::PORT_8, 1'b0, 1'b0, 2'h0);
        run_op(28'h0000A04, 1'b1, bwib_pkg::SZ_LINE, bwib_pkg::PORT_32, 1'b0, 1'b0, 2'h0);
        end_of_test();
    end
endmodule : burst_write_inhibited_read_bus_tb
